// ### src/cpc_config_bank.sv
// Page 1 configuration bank: filter update enable, serial port role override, ADC custom max channels.
// Assumes a control bus decoder (I2C or SPI) that presents one byte access per cycle on mclk,
// and the page register held outside, presented on reg_page.
//
// Behaviour
// - Bit 0 set permits runtime biquad changes.
// - Primary override clear: role from controller bit.
// - Primary override: no autodetect, split clock directions.
// - Secondary override clear: role from controller bit.
// - Secondary override: no autodetect, split clock directions.
// - Primary controller uses internal frame sync when bit 2.
// - Secondary controller uses internal frame sync when bit 1.
// - Bit 7 picks custom over standard max channels.
// - Custom mask bit 6 is channel four, 3 one.
// - Offsets decode only within the selected page.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_regs.svh"

module cpc_config_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register access from the control bus decoder
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_hit,
    // Filter datapath
    input wire logic biquad_coef_wr_req,
    input wire logic audio_running,
    output logic runtime_biquad_update_en,
    output logic biquad_coef_wr_allow,
    // Primary audio port
    input wire logic primary_controller_sel,
    output logic primary_bclk_oe,
    output logic primary_frame_sync_oe,
    output logic primary_autodetect_en,
    output logic primary_frame_sync_internal,
    // Secondary audio port
    input wire logic secondary_controller_sel,
    output logic secondary_bclk_oe,
    output logic secondary_frame_sync_oe,
    output logic secondary_autodetect_en,
    output logic secondary_frame_sync_internal,
    // ADC dynamic channel power
    input wire logic adc_dynamic_mode,
    input wire logic [3:0] adc_standard_maxch_select,
    output logic adc_custom_maxch_force,
    output logic channel_one_enable,
    output logic channel_two_enable,
    output logic channel_three_enable,
    output logic channel_four_enable
);

    logic [7:0] filter_update_cfg_reg;
    logic [7:0] serial_clock_cfg_reg;
    logic [7:0] adc_channel_power_cfg_reg;
    logic page_hit;
    logic sel_filter;
    logic sel_clock;
    logic sel_channel;
    logic [7:0] rdata_next;
    logic [3:0] custom_mask;
    logic [3:0] max_channel_next;
    logic prim_bclk_drive;
    logic prim_fs_drive;
    logic prim_autodet;
    logic prim_int_fs;
    logic sec_bclk_drive;
    logic sec_fs_drive;
    logic sec_autodet;
    logic sec_int_fs;
    cpc_pkg::cpc_role_t prim_role;
    cpc_pkg::cpc_role_t sec_role;

    // Address decode; other pages never touch this bank
    assign page_hit = (reg_page == `CPC_PAGE_SEL);
    assign sel_filter = page_hit && (reg_addr == `CPC_FILTER_UPDATE_CFG_OFF);
    assign sel_clock = page_hit && (reg_addr == `CPC_SERIAL_CLOCK_CFG_OFF);
    assign sel_channel = page_hit && (reg_addr == `CPC_ADC_CHANNEL_POWER_CFG_OFF);

    // Register writes; reserved positions are masked so they hold their reset value
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            filter_update_cfg_reg <= `CPC_FILTER_UPDATE_CFG_RST;
        end else if (reg_wr && sel_filter) begin
            filter_update_cfg_reg <= reg_wdata & `CPC_FILTER_UPDATE_CFG_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serial_clock_cfg_reg <= `CPC_SERIAL_CLOCK_CFG_RST;
        end else if (reg_wr && sel_clock) begin
            serial_clock_cfg_reg <= reg_wdata & `CPC_SERIAL_CLOCK_CFG_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adc_channel_power_cfg_reg <= `CPC_ADC_CHANNEL_POWER_CFG_RST;
        end else if (reg_wr && sel_channel) begin
            adc_channel_power_cfg_reg <= reg_wdata & `CPC_ADC_CHANNEL_POWER_CFG_WMASK;
        end
    end

    // Read mux; unmapped offsets and foreign pages read zero
    always_comb begin
        rdata_next = 8'h00;
        if (sel_filter) begin
            rdata_next = filter_update_cfg_reg;
        end else if (sel_clock) begin
            rdata_next = serial_clock_cfg_reg;
        end else if (sel_channel) begin
            rdata_next = adc_channel_power_cfg_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
            reg_hit <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            reg_hit <= (reg_rd || reg_wr) && (sel_filter || sel_clock || sel_channel);
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // Coefficient updates while audio runs need the runtime permission
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            runtime_biquad_update_en <= 1'b0;
            biquad_coef_wr_allow <= 1'b0;
        end else begin
            runtime_biquad_update_en <= filter_update_cfg_reg[`CPC_RUNTIME_BIQUAD_UPDATE_EN_BIT];
            biquad_coef_wr_allow <= biquad_coef_wr_req &&
                (!audio_running || filter_update_cfg_reg[`CPC_RUNTIME_BIQUAD_UPDATE_EN_BIT]);
        end
    end

    cpc_port_role u_primary_role (
        .role_override(serial_clock_cfg_reg[`CPC_PRIMARY_ROLE_OVERRIDE_BIT]),
        .controller_sel(primary_controller_sel),
        .internal_framesync(serial_clock_cfg_reg[`CPC_PRIMARY_INTERNAL_FRAMESYNC_BIT]),
        .role(prim_role),
        .bclk_drive(prim_bclk_drive),
        .frame_sync_drive(prim_fs_drive),
        .autodetect_en(prim_autodet),
        .use_internal_frame_sync(prim_int_fs)
    );

    cpc_port_role u_secondary_role (
        .role_override(serial_clock_cfg_reg[`CPC_SECONDARY_ROLE_OVERRIDE_BIT]),
        .controller_sel(secondary_controller_sel),
        .internal_framesync(serial_clock_cfg_reg[`CPC_SECONDARY_INTERNAL_FRAMESYNC_BIT]),
        .role(sec_role),
        .bclk_drive(sec_bclk_drive),
        .frame_sync_drive(sec_fs_drive),
        .autodetect_en(sec_autodet),
        .use_internal_frame_sync(sec_int_fs)
    );

    // Primary port directions, registered so pad enables never glitch
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            primary_bclk_oe <= 1'b0;
            primary_frame_sync_oe <= 1'b0;
            primary_autodetect_en <= 1'b1;
            primary_frame_sync_internal <= 1'b0;
        end else begin
            primary_bclk_oe <= prim_bclk_drive;
            primary_frame_sync_oe <= prim_fs_drive;
            primary_autodetect_en <= prim_autodet;
            // A split role with bit clock out takes frame sync from outside
            primary_frame_sync_internal <= prim_int_fs && (prim_role == cpc_pkg::CPC_ROLE_CONTROLLER);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            secondary_bclk_oe <= 1'b0;
            secondary_frame_sync_oe <= 1'b0;
            secondary_autodetect_en <= 1'b1;
            secondary_frame_sync_internal <= 1'b0;
        end else begin
            secondary_bclk_oe <= sec_bclk_drive;
            secondary_frame_sync_oe <= sec_fs_drive;
            secondary_autodetect_en <= sec_autodet;
            secondary_frame_sync_internal <= sec_int_fs && (sec_role == cpc_pkg::CPC_ROLE_CONTROLLER);
        end
    end

    // ADC maximum channel set; outside dynamic mode every channel enable is cleared here
    assign custom_mask = adc_channel_power_cfg_reg[`CPC_ADC_CUSTOM_CHANNEL_MASK_MSB:`CPC_ADC_CUSTOM_CHANNEL_MASK_LSB];

    always_comb begin
        if (!adc_dynamic_mode) begin
            max_channel_next = 4'h0;
        end else if (adc_channel_power_cfg_reg[`CPC_ADC_CUSTOM_MAXCH_FORCE_BIT]) begin
            max_channel_next = custom_mask;
        end else begin
            max_channel_next = adc_standard_maxch_select;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adc_custom_maxch_force <= 1'b0;
            channel_one_enable <= 1'b0;
            channel_two_enable <= 1'b0;
            channel_three_enable <= 1'b0;
            channel_four_enable <= 1'b0;
        end else begin
            adc_custom_maxch_force <= adc_channel_power_cfg_reg[`CPC_ADC_CUSTOM_MAXCH_FORCE_BIT];
            channel_one_enable <= max_channel_next[0];
            channel_two_enable <= max_channel_next[1];
            channel_three_enable <= max_channel_next[2];
            channel_four_enable <= max_channel_next[3];
        end
    end

endmodule // cpc_config_bank

`default_nettype wire

// ### src/cpc_pkg.sv
// Types shared by the page 1 configuration bank and its port role resolver.
// Assumes nothing of its surroundings.
`default_nettype none

package cpc_pkg;

    // Resolved role of one audio serial port
    typedef enum logic [1:0] {
        CPC_ROLE_TARGET = 2'b00,
        CPC_ROLE_CONTROLLER = 2'b01,
        CPC_ROLE_OVR_BCLK_IN = 2'b10,
        CPC_ROLE_OVR_BCLK_OUT = 2'b11
    } cpc_role_t;

endpackage

`default_nettype wire

// ### src/cpc_port_role.sv
// Resolves the bit clock and frame sync direction of one audio serial port.
// Assumes its inputs are stable register fields in the mclk domain; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module cpc_port_role (
    // Configuration fields
    input wire logic role_override,
    input wire logic controller_sel,
    input wire logic internal_framesync,
    // Resolved behaviour
    output cpc_pkg::cpc_role_t role,
    output logic bclk_drive,
    output logic frame_sync_drive,
    output logic autodetect_en,
    output logic use_internal_frame_sync
);

    always_comb begin
        unique case ({role_override, controller_sel})
            2'b00: role = cpc_pkg::CPC_ROLE_TARGET;
            2'b01: role = cpc_pkg::CPC_ROLE_CONTROLLER;
            2'b10: role = cpc_pkg::CPC_ROLE_OVR_BCLK_IN;
            2'b11: role = cpc_pkg::CPC_ROLE_OVR_BCLK_OUT;
        endcase
    end

    always_comb begin
        bclk_drive = 1'b0;
        frame_sync_drive = 1'b0;
        autodetect_en = 1'b1;
        unique case (role)
            cpc_pkg::CPC_ROLE_TARGET: begin
                bclk_drive = 1'b0;
                frame_sync_drive = 1'b0;
            end
            cpc_pkg::CPC_ROLE_CONTROLLER: begin
                bclk_drive = 1'b1;
                frame_sync_drive = 1'b1;
            end
            // Split roles cannot be auto-detected, so detection is off
            cpc_pkg::CPC_ROLE_OVR_BCLK_IN: begin
                bclk_drive = 1'b0;
                frame_sync_drive = 1'b1;
                autodetect_en = 1'b0;
            end
            cpc_pkg::CPC_ROLE_OVR_BCLK_OUT: begin
                bclk_drive = 1'b1;
                frame_sync_drive = 1'b0;
                autodetect_en = 1'b0;
            end
        endcase
    end

    // Internal frame sync only matters while the port drives its bit clock as controller
    assign use_internal_frame_sync = controller_sel & internal_framesync;

endmodule // cpc_port_role

`default_nettype wire

// ### src/cpc_regs.svh
// Register offsets, field positions, masks and reset values of the page 1 configuration bank.
// Assumes inclusion by bare name from any design file that needs the map.
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// Page that holds this bank; the page register itself lives outside the bank
`define CPC_PAGE_SEL 8'h01

// Offsets within the page
`define CPC_FILTER_UPDATE_CFG_OFF 8'h03
`define CPC_SERIAL_CLOCK_CFG_OFF 8'h0D
`define CPC_ADC_CHANNEL_POWER_CFG_OFF 8'h0E

// Reset values
`define CPC_FILTER_UPDATE_CFG_RST 8'h00
`define CPC_SERIAL_CLOCK_CFG_RST 8'h00
`define CPC_ADC_CHANNEL_POWER_CFG_RST 8'h00

// Writable bits; every other bit is reserved, read only, reads zero
`define CPC_FILTER_UPDATE_CFG_WMASK 8'h01
`define CPC_SERIAL_CLOCK_CFG_WMASK 8'hC6
`define CPC_ADC_CHANNEL_POWER_CFG_WMASK 8'hF8

// filter_update_cfg fields
`define CPC_RUNTIME_BIQUAD_UPDATE_EN_BIT 0

// serial_clock_cfg fields
`define CPC_PRIMARY_ROLE_OVERRIDE_BIT 7
`define CPC_SECONDARY_ROLE_OVERRIDE_BIT 6
`define CPC_PRIMARY_INTERNAL_FRAMESYNC_BIT 2
`define CPC_SECONDARY_INTERNAL_FRAMESYNC_BIT 1

// adc_channel_power_cfg fields
`define CPC_ADC_CUSTOM_MAXCH_FORCE_BIT 7
`define CPC_ADC_CUSTOM_CHANNEL_MASK_MSB 6
`define CPC_ADC_CUSTOM_CHANNEL_MASK_LSB 3

`endif

// ### tb/codec_page1_config_regs_test.sv
// Self-checking bench: register model and port outputs compared after each round of writes and input changes.
// Assumes the host model drives the register strobes; other inputs are driven here.
`timescale 1ns/1ps
`default_nettype none

module codec_page1_config_regs_test;
    logic mclk = 1'b0, nrst = 1'b0, req = 1'b0, run = 1'b0, pc = 1'b0, sc = 1'b0, dyn = 1'b0;
    logic [3:0] stdsel = 4'h0;
    logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_hit;
    logic [14:0] o;
    logic [5:0] v;
    logic [7:0] offs[3] = '{8'h03, 8'h0D, 8'h0E};
    logic [7:0] wm[3] = '{8'h01, 8'hC6, 8'hF8};
    int m[3] = '{0, 0, 0};
    int errors = 0, checks_done = 0, i, j;
    integer seed = 32'h313F6880;

    always #10 mclk = ~mclk;

    cpc_host_model cpc_host_model_inst (.mclk(mclk), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
    cpc_config_bank cpc_config_bank_inst (.mclk(mclk), .nrst(nrst), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(),
        .reg_hit(reg_hit), .biquad_coef_wr_req(req), .audio_running(run), .runtime_biquad_update_en(o[0]),
        .biquad_coef_wr_allow(o[1]), .primary_controller_sel(pc), .primary_bclk_oe(o[2]),
        .primary_frame_sync_oe(o[3]), .primary_autodetect_en(o[4]), .primary_frame_sync_internal(o[5]),
        .secondary_controller_sel(sc), .secondary_bclk_oe(o[6]), .secondary_frame_sync_oe(o[7]),
        .secondary_autodetect_en(o[8]), .secondary_frame_sync_internal(o[9]), .adc_dynamic_mode(dyn),
        .adc_standard_maxch_select(stdsel), .adc_custom_maxch_force(o[10]), .channel_one_enable(o[11]),
        .channel_two_enable(o[12]), .channel_three_enable(o[13]), .channel_four_enable(o[14]));

    task automatic chk(input logic [14:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int idx(input logic [7:0] a);
        for (int n = 0; n < 3; n++) if (a === offs[n]) return n;
        return 3;
    endfunction

    function automatic logic [14:0] model();
        logic [14:0] e;
        logic ovr, ctl;
        e = 15'h0000;
        e[0] = m[0][0];
        e[1] = req && (!run || m[0][0]);
        for (int k = 0; k < 2; k++) begin
            ovr = m[1][7-k];
            ctl = k ? sc : pc;
            e[2+4*k +: 4] = {!ovr && ctl && m[1][2-k], !ovr, ctl ^ ovr, ctl};
        end
        e[10] = m[2][7];
        e[14:11] = !dyn ? 4'h0 : m[2][7] ? m[2][6:3] : stdsel;
        return e;
    endfunction

    task automatic wr(input logic [7:0] pg, a, d);
        logic [7:0] rd;
        logic h;
        int n;
        n = idx(a);
        // The bench clears reserved positions of the bank before the write, so they keep their reset value
        if (pg == 8'h01 && n < 3) d = d & wm[n];
        cpc_host_model_inst.xfer(pg, a, d, 1'b1, rd, h);
        chk(15'(h), 15'(pg == 8'h01 && n < 3));
        if (pg == 8'h01 && n < 3) m[n] = d & wm[n];
    endtask

    task automatic rdchk(input logic [7:0] a);
        logic [7:0] rd;
        logic h;
        int n;
        n = idx(a);
        cpc_host_model_inst.xfer(8'h01, a, 8'h00, 1'b0, rd, h);
        chk(15'(h), 15'(n < 3));
        chk(15'(rd), n < 3 ? 15'(m[n][7:0]) : 15'h0000);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (19) @(posedge mclk);
        #1 chk(o, model());
        @(posedge mclk);
        nrst <= 1'b1;
        for (j = 0; j < 3; j++) rdchk(offs[j]);
        $display("reset values test done");
        // Every override, controller and internal frame sync combination on both ports
        for (i = 0; i < 64; i++) begin
            v = 6'(i);
            wr(8'h01, 8'h03, 8'($random(seed)));
            wr(8'h01, 8'h0D, (8'($random(seed)) & 8'h39) | {v[0], v[1], 3'h0, v[2], v[3], 1'h0});
            wr(8'h01, 8'h0E, 8'($random(seed)));
            wr(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
            for (j = 0; j < 3; j++) rdchk(offs[j]);
            rdchk(8'h0F);
            @(posedge mclk);
            pc <= v[4];
            sc <= v[5];
            req <= 1'($random(seed));
            run <= 1'($random(seed));
            dyn <= 1'($random(seed));
            stdsel <= 4'($random(seed));
            repeat (2) @(posedge mclk);
            #1 chk(o, model());
        end
        $display("register and role test done");
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(o, 15'h0110);
        @(posedge mclk);
        nrst <= 1'b1;
        m = '{0, 0, 0};
        for (j = 0; j < 3; j++) rdchk(offs[j]);
        #1 chk(o, model());
        $display("second reset test done");
        report_and_stop();
    end
endmodule // codec_page1_config_regs_test

`default_nettype wire

// ### tb/cpc_config_bank_checker.sv
// Concurrent checks on the ports of the page 1 configuration bank.
// Assumes one mclk domain and a synchronous active-low nrst.
`timescale 1ns/1ps
`default_nettype none

module cpc_config_bank_checker (
    // Clock, reset and register access
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rd_valid,
    input wire logic reg_hit,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // Filter and port roles
    input wire logic biquad_coef_wr_req,
    input wire logic biquad_coef_wr_allow,
    input wire logic primary_controller_sel,
    input wire logic primary_bclk_oe,
    input wire logic primary_frame_sync_oe,
    input wire logic primary_autodetect_en,
    input wire logic primary_frame_sync_internal,
    input wire logic secondary_controller_sel,
    input wire logic secondary_bclk_oe,
    input wire logic secondary_frame_sync_oe,
    input wire logic secondary_autodetect_en,
    input wire logic secondary_frame_sync_internal,
    // ADC channels
    input wire logic adc_dynamic_mode,
    input wire logic channel_one_enable,
    input wire logic channel_four_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_rd_valid;
        reg_rd |=> reg_rd_valid && reg_hit == $past(reg_page == 8'h01
            && (reg_addr == 8'h03 || reg_addr == 8'h0D || reg_addr == 8'h0E));
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read answer or hit wrong");
    property p_page;
        (reg_wr || reg_rd) && reg_page != 8'h01 |=> !reg_hit;
    endproperty
    a_page: assert property (p_page) else $error("access on another page hit");
    property p_rsv;
        reg_rd && reg_addr == 8'h0D |=> reg_rdata[5:3] == 3'h0 && !reg_rdata[0];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved clock bits not zero");
    property p_allow;
        biquad_coef_wr_allow |-> $past(biquad_coef_wr_req);
    endproperty
    a_allow: assert property (p_allow) else $error("coefficient load allowed unasked");
    property p_pri_follow;
        $past(nrst) |-> primary_bclk_oe == $past(primary_controller_sel);
    endproperty
    a_pri_follow: assert property (p_pri_follow) else $error("primary bit clock ignores controller bit");
    property p_pri_split;
        (primary_frame_sync_oe == primary_bclk_oe) == primary_autodetect_en;
    endproperty
    a_pri_split: assert property (p_pri_split) else $error("primary override directions wrong");
    property p_sec_split;
        (secondary_frame_sync_oe == secondary_bclk_oe) == secondary_autodetect_en;
    endproperty
    a_sec_split: assert property (p_sec_split) else $error("secondary override directions wrong");
    property p_pri_int;
        primary_frame_sync_internal |-> primary_autodetect_en && primary_bclk_oe;
    endproperty
    a_pri_int: assert property (p_pri_int) else $error("internal frame sync outside controller");
    property p_sec_follow;
        $past(nrst) |-> secondary_bclk_oe == $past(secondary_controller_sel);
    endproperty
    a_sec_follow: assert property (p_sec_follow) else $error("secondary bit clock ignores controller bit");
    property p_sec_int;
        secondary_frame_sync_internal |-> secondary_autodetect_en && secondary_bclk_oe;
    endproperty
    a_sec_int: assert property (p_sec_int) else $error("secondary internal frame sync outside controller");
    property p_adc;
        !$past(adc_dynamic_mode) |-> !channel_one_enable && !channel_four_enable;
    endproperty
    a_adc: assert property (p_adc) else $error("channels enabled outside dynamic mode");
endmodule // cpc_config_bank_checker

bind cpc_config_bank cpc_config_bank_checker cpc_config_bank_checker_inst (.mclk(mclk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .biquad_coef_wr_req(biquad_coef_wr_req),
    .biquad_coef_wr_allow(biquad_coef_wr_allow), .primary_controller_sel(primary_controller_sel),
    .primary_bclk_oe(primary_bclk_oe), .primary_frame_sync_oe(primary_frame_sync_oe),
    .primary_autodetect_en(primary_autodetect_en), .primary_frame_sync_internal(primary_frame_sync_internal),
    .secondary_controller_sel(secondary_controller_sel),
    .secondary_bclk_oe(secondary_bclk_oe), .secondary_frame_sync_oe(secondary_frame_sync_oe),
    .secondary_autodetect_en(secondary_autodetect_en),
    .secondary_frame_sync_internal(secondary_frame_sync_internal), .adc_dynamic_mode(adc_dynamic_mode),
    .channel_one_enable(channel_one_enable), .channel_four_enable(channel_four_enable));

`default_nettype wire

// ### tb/cpc_host_model.sv
// Host on the control bus: one byte access per call, strobes as single-cycle pulses.
// Assumes the caller waits for the task to return before the next access.
`timescale 1ns/1ps
`default_nettype none

module cpc_host_model (
    // Clock
    input wire logic mclk,
    // Register access
    output logic [7:0] reg_page,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    initial begin
        {reg_page, reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0000000;
    end

    task automatic xfer(input logic [7:0] p, a, d, input logic w, output logic [7:0] rd, output logic h);
        @(posedge mclk);
        reg_page <= p;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Released lines flip so stale values never look valid
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
        rd = reg_rdata;
        h = reg_hit;
    endtask
endmodule // cpc_host_model

`default_nettype wire
